// ===== common/mbs_pkg.sv
// constants for the panel mode button sequencer
// assumes a single 200 MHz core clock
package mbs_pkg;
    // ------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MBS_NORMAL,
        MBS_TX_TEST,
        MBS_RX_TEST,
        MBS_SS_TEST
    } mbs_mode_t;

    // ------------------------------------------------------------
    // lamp colour codes {green, red}
    // ------------------------------------------------------------
    localparam logic [1:0] LAMP_OFF    = 2'h0;
    localparam logic [1:0] LAMP_RED    = 2'h1;
    localparam logic [1:0] LAMP_GREEN  = 2'h2;
    localparam logic [1:0] LAMP_ORANGE = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 200_000_000;
    localparam int HOLD_MS       = 2000;
    localparam int HOLD_CYCLES   = HOLD_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_MS   = 10;
    localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
    // a minute of core cycles does not fit in 32 bits
    localparam longint MINUTE_CYCLES = longint'(60) * longint'(CLK_HZ);
    localparam int MINUTES_W     = 8;
endpackage

// ===== design/mbs_sequencer.sv
// panel mode button sequencer: button debounce, mode state, lamps, test timer
// assumes button pin is asynchronous; menu and radio status are core-clock logic
//
// Notes on behaviour
// - reset gives normal mode, mode lamp off
// - short press from normal: transmit, red
// - short press from transmit: receive, green
// - short press from receive: signal strength, orange
// - short press from signal strength wraps to transmit
// - hold two seconds returns to normal
// - hold reached: both lamps orange until release, then mode lamp off
// - test period expiry reboots into normal
// - timer minutes set by menu only
// - enables: normal both, transmit tx, receive rx
// - signal strength mode shows fade margin lamp
// - otherwise activity lamp shows tx, rx, listen
// - menu and button share one mode state
`timescale 1ns/100ps
module mbs_sequencer
    import mbs_pkg::*;
#(
    parameter int     HOLD_CYC   = mbs_pkg::HOLD_CYCLES,
    parameter int     DEB_CYC    = mbs_pkg::DEBOUNCE_CYC,
    parameter longint MINUTE_CYC = mbs_pkg::MINUTE_CYCLES
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_mode_button,
    input  wire logic                  i_menu_mode_set,
    input  wire mbs_pkg::mbs_mode_t    i_menu_mode,
    input  wire logic [mbs_pkg::MINUTES_W-1:0] i_menu_test_minutes,
    input  wire logic                  i_radio_tx_active,
    input  wire logic                  i_radio_rx_active,
    input  wire logic [1:0]            i_fade_margin_colour,
    output logic [1:0]                 o_mode_lamp,
    output logic [1:0]                 o_radio_activity_lamp,
    output mbs_pkg::mbs_mode_t         o_mode,
    output logic                       o_tx_enable,
    output logic                       o_rx_enable,
    output logic                       o_test_reboot
);
    import mbs_pkg::*;

    // refused at elaboration: the counters are 32 and 40 bits wide
    if (HOLD_CYC < 2 || DEB_CYC < 1 || MINUTE_CYC < 2 || DEB_CYC >= HOLD_CYC
        || MINUTE_CYC > 64'h00ff_ffff_ffff) begin : g_bad_timing
        $error("mbs_sequencer: bad timing parameters");
    end

    // ------------------------------------------------------------
    // button synchroniser and debounce
    // ------------------------------------------------------------
    logic [2:0]  sync;
    logic        btn;
    logic [31:0] deb_cnt;
    logic        next_btn;
    logic [31:0] next_deb_cnt;

    always_comb begin
        next_btn     = btn;
        next_deb_cnt = 32'h0;
        // stage 0 only feeds stage 1; the filter compares stages 1 and 2
        if (sync[1] == sync[2] && sync[2] != btn) begin
            if (deb_cnt == 32'(DEB_CYC - 1))
                next_btn = sync[2];
            else
                next_deb_cnt = deb_cnt + 32'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            sync    <= 3'h0;
            btn     <= 1'b0;
            deb_cnt <= 32'h0;
        end else begin
            sync    <= {sync[1:0], i_mode_button};
            btn     <= next_btn;
            deb_cnt <= next_deb_cnt;
        end
    end

    // ------------------------------------------------------------
    // press classification
    // ------------------------------------------------------------
    logic        btn_q;
    logic [31:0] hold_cnt;
    logic        long_seen;
    logic [31:0] next_hold_cnt;
    logic        next_long_seen;
    logic        short_evt;
    logic        long_evt;

    always_comb begin
        next_hold_cnt  = hold_cnt;
        next_long_seen = long_seen;
        long_evt       = 1'b0;
        short_evt      = 1'b0;
        if (btn && !btn_q) begin
            next_hold_cnt  = 32'h1;
            next_long_seen = 1'b0;
        end else if (btn) begin
            if (!long_seen && hold_cnt == 32'(HOLD_CYC - 1)) begin
                long_evt       = 1'b1;
                next_long_seen = 1'b1;
            end else if (!long_seen) begin
                next_hold_cnt = hold_cnt + 32'h1;
            end
        end else if (btn_q) begin
            short_evt      = !long_seen;
            next_long_seen = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            btn_q     <= 1'b0;
            hold_cnt  <= 32'h0;
            long_seen <= 1'b0;
        end else begin
            btn_q     <= btn;
            hold_cnt  <= next_hold_cnt;
            long_seen <= next_long_seen;
        end
    end

    // ------------------------------------------------------------
    // shared mode state and test timer
    // ------------------------------------------------------------
    mbs_mode_t           mode;
    mbs_mode_t           next_mode;
    logic [39:0]         tick_cnt;
    logic [39:0]         next_tick_cnt;
    logic [MINUTES_W:0]  min_cnt;
    logic [MINUTES_W:0]  next_min_cnt;
    logic                reboot;
    logic                next_reboot;
    logic                expire;

    // timer restarts whenever normal mode is left
    assign expire = (mode != MBS_NORMAL) && tick_cnt == 40'(MINUTE_CYC - 1)
                    && (min_cnt + 9'h1) >= {1'b0, i_menu_test_minutes};

    always_comb begin
        next_mode     = mode;
        next_tick_cnt = 40'h0;
        next_min_cnt  = '0;
        next_reboot   = 1'b0;
        if (expire) begin
            next_mode   = MBS_NORMAL;
            next_reboot = 1'b1;
        end else if (long_evt) begin
            next_mode = MBS_NORMAL;
        end else if (i_menu_mode_set) begin
            next_mode = i_menu_mode;
        end else if (short_evt) begin
            unique case (mode)
                MBS_NORMAL:  next_mode = MBS_TX_TEST;
                MBS_TX_TEST: next_mode = MBS_RX_TEST;
                MBS_RX_TEST: next_mode = MBS_SS_TEST;
                MBS_SS_TEST: next_mode = MBS_TX_TEST;
            endcase
        end
        if (mode != MBS_NORMAL && next_mode != MBS_NORMAL) begin
            if (tick_cnt == 40'(MINUTE_CYC - 1)) begin
                next_min_cnt = min_cnt + 9'h1;
            end else begin
                next_tick_cnt = tick_cnt + 40'h1;
                next_min_cnt  = min_cnt;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            mode     <= MBS_NORMAL;
            tick_cnt <= 40'h0;
            min_cnt  <= '0;
            reboot   <= 1'b0;
        end else begin
            mode     <= next_mode;
            tick_cnt <= next_tick_cnt;
            min_cnt  <= next_min_cnt;
            reboot   <= next_reboot;
        end
    end

    // ------------------------------------------------------------
    // lamps and radio enables
    // ------------------------------------------------------------
    logic [1:0] next_mode_lamp;
    logic [1:0] next_act_lamp;
    logic       next_tx_en;
    logic       next_rx_en;

    always_comb begin
        next_tx_en = (mode != MBS_RX_TEST) && (mode != MBS_SS_TEST);
        next_rx_en = (mode != MBS_TX_TEST);
        unique case (mode)
            MBS_NORMAL:  next_mode_lamp = LAMP_OFF;
            MBS_TX_TEST: next_mode_lamp = LAMP_RED;
            MBS_RX_TEST: next_mode_lamp = LAMP_GREEN;
            MBS_SS_TEST: next_mode_lamp = LAMP_ORANGE;
        endcase
        if (mode == MBS_SS_TEST)
            next_act_lamp = i_fade_margin_colour;
        else if (i_radio_tx_active)
            next_act_lamp = LAMP_RED;
        else if (i_radio_rx_active)
            next_act_lamp = LAMP_GREEN;
        else
            next_act_lamp = LAMP_OFF;
        // still held after the long hold fired: both lamps orange
        if (long_seen && btn) begin
            next_mode_lamp = LAMP_ORANGE;
            next_act_lamp  = LAMP_ORANGE;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_mode_lamp           <= LAMP_OFF;
            o_radio_activity_lamp <= LAMP_OFF;
            o_tx_enable           <= 1'b0;
            o_rx_enable           <= 1'b0;
        end else begin
            o_mode_lamp           <= next_mode_lamp;
            o_radio_activity_lamp <= next_act_lamp;
            o_tx_enable           <= next_tx_en;
            o_rx_enable           <= next_rx_en;
        end
    end

    assign o_mode        = mode;
    assign o_test_reboot = reboot;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_release_short;
        btn_q && !btn && !long_seen;
    endsequence

    a_short_tx_red: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (s_release_short and mode == MBS_NORMAL && !i_menu_mode_set && !expire)
        |=> mode == MBS_TX_TEST ##1 o_mode_lamp == LAMP_RED)
        else $error("short press from normal did not give transmit");
    a_tx_to_rx: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (s_release_short and mode == MBS_TX_TEST && !i_menu_mode_set && !expire)
        |=> mode == MBS_RX_TEST ##1 o_mode_lamp == LAMP_GREEN)
        else $error("transmit did not advance to receive");
    a_rx_to_ss: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (s_release_short and mode == MBS_RX_TEST && !i_menu_mode_set && !expire)
        |=> mode == MBS_SS_TEST)
        else $error("receive did not advance to signal strength");
    a_ss_wraps: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (s_release_short and mode == MBS_SS_TEST && !i_menu_mode_set && !expire)
        |=> mode == MBS_TX_TEST)
        else $error("signal strength did not wrap to transmit");
    a_long_normal: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        long_evt && !expire |=> mode == MBS_NORMAL)
        else $error("long hold did not give normal");
    a_long_no_adv: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        btn_q && !btn && long_seen && !i_menu_mode_set |=> $stable(mode))
        else $error("release after long hold moved the mode");
    a_hold_lamps: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        long_seen && btn |=> o_mode_lamp == LAMP_ORANGE
        && o_radio_activity_lamp == LAMP_ORANGE)
        else $error("lamps not orange during long hold");
    a_expire_boot: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        expire |=> o_test_reboot && mode == MBS_NORMAL ##1 !o_test_reboot)
        else $error("expiry did not reboot into normal");
    a_enables: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        mode == MBS_TX_TEST && $stable(mode) |=> o_tx_enable && !o_rx_enable)
        else $error("transmit test enables wrong");
    a_menu_mode: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_menu_mode_set && !long_evt && !expire |=> mode == $past(i_menu_mode))
        else $error("menu mode not taken");
    a_reset_normal: assert property (@(posedge i_core_clk)
        !i_resetn |=> mode == MBS_NORMAL && o_mode_lamp == LAMP_OFF)
        else $error("reset did not give normal with lamp off");
    a_ss_fade: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        mode == MBS_SS_TEST && !(long_seen && btn)
        |=> o_radio_activity_lamp == $past(i_fade_margin_colour))
        else $error("fade margin not shown in signal strength mode");
endmodule

// ===== bench/mbs_operator.sv
// panel operator model: presses the mode button with contact bounce
// assumes the bench calls press() from one process at a time
`timescale 1ns/100ps
module mbs_operator (
    input  wire logic i_core_clk,
    output logic      o_button
);
    initial o_button = 1'b0;

    // ------------------------------------------------------------
    // one press: bounce on make, hold, bounce on break
    // ------------------------------------------------------------
    task automatic press(input int hold);
        int i;
        for (i = 0; i < 5; i++) begin
            @(negedge i_core_clk);
            o_button = ~i[0];
        end
        repeat (hold) @(negedge i_core_clk); // hold >= HOLD_CYC asks for normal
        for (i = 0; i < 5; i++) begin
            @(negedge i_core_clk);
            o_button = i[0];
        end
        // idle gap so the next press is not merged into this one
        repeat (25) @(negedge i_core_clk);
    endtask
endmodule

// ===== bench/mode_button_test_sequencer_bench.sv
// self-checking bench for the panel mode button sequencer
// assumes shortened hold, debounce and minute counts set below
`timescale 1ns/100ps
module mode_button_test_sequencer_bench;
    import mbs_pkg::*;
    logic            i_core_clk;
    logic            i_resetn;
    logic            i_menu_mode_set;
    mbs_mode_t       i_menu_mode;
    logic [7:0]      i_menu_test_minutes;
    logic            i_radio_tx_active;
    logic            i_radio_rx_active;
    logic [1:0]      i_fade_margin_colour;
    logic            btn;
    logic [1:0]      o_mode_lamp;
    logic [1:0]      o_radio_activity_lamp;
    mbs_mode_t       o_mode;
    logic            o_tx_enable;
    logic            o_rx_enable;
    logic            o_test_reboot;
    logic [7:0]      q[$];
    logic [7:0]      got;
    logic [7:0]      e;
    int              miscompares = 0;
    int              tests_run = 0;
    int              cycles = 0;
    int              reboots = 0;

    mbs_sequencer #(.HOLD_CYC(20), .DEB_CYC(3), .MINUTE_CYC(10)) dut (
        .i_core_clk           (i_core_clk),
        .i_resetn             (i_resetn),
        .i_mode_button        (btn),
        .i_menu_mode_set      (i_menu_mode_set),
        .i_menu_mode          (i_menu_mode),
        .i_menu_test_minutes  (i_menu_test_minutes),
        .i_radio_tx_active    (i_radio_tx_active),
        .i_radio_rx_active    (i_radio_rx_active),
        .i_fade_margin_colour (i_fade_margin_colour),
        .o_mode_lamp          (o_mode_lamp),
        .o_radio_activity_lamp(o_radio_activity_lamp),
        .o_mode               (o_mode),
        .o_tx_enable          (o_tx_enable),
        .o_rx_enable          (o_rx_enable),
        .o_test_reboot        (o_test_reboot)
    );
    mbs_operator op (.i_core_clk(i_core_clk), .o_button(btn));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    function automatic logic [7:0] ex(input mbs_mode_t m, input logic [1:0] ml,
                                      input logic [1:0] al, input logic t, input logic r);
        return {m, ml, al, t, r};
    endfunction
    // settled outputs of a mode with no button held, from the current inputs
    function automatic logic [7:0] exm(input mbs_mode_t m);
        logic [1:0] ml;
        logic [1:0] al;
        ml = (m == MBS_TX_TEST) ? LAMP_RED : (m == MBS_RX_TEST) ? LAMP_GREEN
           : (m == MBS_SS_TEST) ? LAMP_ORANGE : LAMP_OFF;
        al = (m == MBS_SS_TEST) ? i_fade_margin_colour : i_radio_tx_active ? LAMP_RED
           : i_radio_rx_active ? LAMP_GREEN : LAMP_OFF;
        return {m, ml, al, m == MBS_NORMAL || m == MBS_TX_TEST,
                m == MBS_NORMAL || m == MBS_RX_TEST};
    endfunction
    task automatic close_out();
        $display("compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cycles++;
        if (o_test_reboot === 1'b1)
            reboots++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // watcher: each mode change is judged at the second falling clock edge after it
    // ------------------------------------------------------------
    initial begin
        wait (i_resetn === 1'b1);
        forever begin
            @(o_mode);
            repeat (2) @(negedge i_core_clk);
            got = {o_mode, o_mode_lamp, o_radio_activity_lamp, o_tx_enable, o_rx_enable};
            e = (q.size() > 0) ? q.pop_front() : 8'hxx;
            // enables in signal strength mode are left open
            if (e[7:6] === MBS_SS_TEST)
                got[1:0] = e[1:0];
            chk(got, e);
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(90447));
        i_resetn = 1'b0;
        i_menu_mode_set = 1'b0;
        i_menu_mode = MBS_NORMAL;
        i_menu_test_minutes = 8'hff;
        i_radio_tx_active = 1'($urandom);
        i_radio_rx_active = 1'($urandom);
        i_fade_margin_colour = 2'($urandom);
        repeat (20) @(negedge i_core_clk);
        i_resetn = 1'b1;
        repeat (3) @(negedge i_core_clk);
        chk({o_mode, o_mode_lamp}, {MBS_NORMAL, LAMP_OFF});
        q.push_back(exm(MBS_TX_TEST));
        op.press(6);
        q.push_back(exm(MBS_RX_TEST));
        op.press(6);
        q.push_back(exm(MBS_SS_TEST));
        op.press(6);
        q.push_back(exm(MBS_TX_TEST));
        op.press(6);
        q.push_back(ex(MBS_NORMAL, LAMP_ORANGE, LAMP_ORANGE, 1'b1, 1'b1));
        op.press(40);
        chk(o_mode_lamp, LAMP_OFF);
        @(negedge i_core_clk);
        i_menu_mode = MBS_SS_TEST;
        i_menu_mode_set = 1'b1;
        q.push_back(exm(MBS_SS_TEST));
        @(negedge i_core_clk);
        i_menu_mode_set = 1'b0;
        repeat (10) @(negedge i_core_clk);
        q.push_back(exm(MBS_TX_TEST));
        op.press(6);
        q.push_back(ex(MBS_NORMAL, LAMP_ORANGE, LAMP_ORANGE, 1'b1, 1'b1));
        op.press(40);
        // short test period: the unit must fall back alone
        i_menu_test_minutes = 8'($urandom_range(3, 1));
        q.push_back(exm(MBS_TX_TEST));
        q.push_back(exm(MBS_NORMAL));
        op.press(6);
        repeat (60) @(negedge i_core_clk);
        chk(reboots, 1);
        i_radio_tx_active = 1'b1;
        repeat (3) @(negedge i_core_clk);
        chk(o_radio_activity_lamp, LAMP_RED);
        i_radio_tx_active = 1'b0;
        i_radio_rx_active = 1'b0;
        repeat (3) @(negedge i_core_clk);
        chk(o_radio_activity_lamp, LAMP_OFF);
        // reset in mid-test, well before the test period can run out
        @(negedge i_core_clk);
        i_menu_mode = mbs_mode_t'($urandom_range(3, 1));
        i_menu_mode_set = 1'b1;
        q.push_back(exm(i_menu_mode));
        @(negedge i_core_clk);
        i_menu_mode_set = 1'b0;
        repeat (3) @(negedge i_core_clk);
        i_resetn = 1'b0;
        q.push_back(ex(MBS_NORMAL, LAMP_OFF, LAMP_OFF, 1'b0, 1'b0));
        repeat (5) @(negedge i_core_clk);
        i_resetn = 1'b1;
        repeat (2) @(negedge i_core_clk);
        chk({o_mode, o_mode_lamp, o_tx_enable, o_rx_enable}, {MBS_NORMAL, LAMP_OFF, 2'h3});
        chk(q.size(), 0);
        close_out();
    end
endmodule
